// File: perf_event_bus_encoder.sv
// Event bus encoder for performance events 0x1c to 0x2d
module perf_event_bus_encoder
   import perf_event_pkg::*;
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Retirement of system register writes
   input wire logic i_ttb_write_retired,
   input wire logic i_ttb_write_cond_pass,
   input wire logic [2:0] i_ttb_write_level,
   input wire logic i_ttb_write_base01,
   // Cycle count event
   input wire logic i_cycle_event,
   // Counter overflow, one bit per counter
   input wire logic [`NUM_COUNTERS-1:0] i_counter_overflow,
   input wire logic [`NUM_COUNTERS-1:0] i_counter_sel_chain,
   // L2 allocation lanes
   input wire logic [`MAX_L2ALLOC_LANES-1:0] i_l2_fullline_write,
   input wire logic [`MAX_L2ALLOC_LANES-1:0] i_l2_write_linefill,
   // Branch retirement lanes
   input wire logic [`MAX_BRANCH_LANES-1:0] i_branch_retired,
   input wire logic [`MAX_BRANCH_LANES-1:0] i_branch_condition_fail,
   input wire logic [`MAX_BRANCH_LANES-1:0] i_branch_is_exc_or_dbg,
   input wire logic [`MAX_BRANCH_LANES-1:0] i_branch_mispredicted,
   input wire logic [`MAX_BRANCH_LANES-1:0] i_branch_flush,
   // Dispatch status
   input wire logic i_fetch_available,
   input wire logic i_dispatch_blocked,
   // TLB activity
   input wire logic i_dtlb_load_access,
   input wire logic i_dtlb_store_access,
   input wire logic i_itlb_access,
   input wire logic i_level2_tlb_refill,
   input wire logic i_mmu_enable,
   // L3 and coherence unit traffic
   input wire logic i_l3_fullline_write,
   input wire logic i_l3_write_linefill,
   input wire logic [`MAX_READ_LANES-1:0] i_ccu_read_return,
   input wire logic [`MAX_READ_LANES-1:0] i_ccu_read_cacheable,
   input wire logic [`MAX_READ_LANES-1:0] i_ccu_read_external,
   input wire logic [`MAX_READ_LANES-1:0] i_ccu_read_pf_stash,
   input wire logic i_ccu_write_cacheable,
   // Event bus slice toward trace and counters
   output event_slice_t o_event_bus
);

   // ------------------------------------------------------------------
   // Single-bit event decode
   // ------------------------------------------------------------------
   logic ttb_hit;
   logic chain_hit;
   logic stall_fe;
   logic stall_be;
   logic itlb_hit;
   logic l3_alloc_hit;
   logic l3_access_hit;
   logic l2tlb_hit;
   logic [`NUM_COUNTERS-1:0] chain_lane;

   // Only EL1 bases count; EL2 and EL12 aliases are filtered out
   assign ttb_hit = i_ttb_write_retired & i_ttb_write_cond_pass
                    & i_ttb_write_base01
                    & (i_ttb_write_level == TTB_EL1);

   // An odd counter takes the overflow of the even one below it
   generate
      for (genvar c = 0; c < `NUM_COUNTERS; c++) begin : g_chain
         if (c % 2 == 1) begin : g_odd
            assign chain_lane[c] = i_counter_sel_chain[c]
                                   & i_counter_overflow[c-1];
         end else begin : g_even
            assign chain_lane[c] = 1'b0;
         end
      end
   endgenerate
   assign chain_hit = |chain_lane;

   assign stall_fe = ~i_fetch_available;
   assign stall_be = i_fetch_available & i_dispatch_blocked;
   assign itlb_hit = i_itlb_access;
   assign l3_alloc_hit = i_l3_fullline_write & ~i_l3_write_linefill;
   assign l3_access_hit = (|(i_ccu_read_return & i_ccu_read_cacheable))
                          | i_ccu_write_cacheable;
   assign l2tlb_hit = i_level2_tlb_refill & i_mmu_enable;

   // ------------------------------------------------------------------
   // Multi-lane qualifiers
   // ------------------------------------------------------------------
   logic [`MAX_L2ALLOC_LANES-1:0] l2_alloc_lane;
   logic [`MAX_BRANCH_LANES-1:0] br_lane;
   logic [`MAX_BRANCH_LANES-1:0] mis_lane;
   logic [1:0] dtlb_lane;
   logic [`MAX_READ_LANES-1:0] l3_ref_lane;

   assign l2_alloc_lane = i_l2_fullline_write & ~i_l2_write_linefill;
   assign br_lane = i_branch_retired & ~i_branch_condition_fail
                    & ~i_branch_is_exc_or_dbg;
   assign mis_lane = br_lane & i_branch_mispredicted & i_branch_flush;
   assign dtlb_lane = {i_dtlb_store_access, i_dtlb_load_access};
   // Prefetch and stash fills are dropped before counting
   assign l3_ref_lane = i_ccu_read_return & i_ccu_read_cacheable
                        & i_ccu_read_external
                        & ~i_ccu_read_pf_stash;

   // ------------------------------------------------------------------
   // Counts, registered inside the counter module
   // ------------------------------------------------------------------
   logic [`EVB_L2ALLOC_W-1:0] l2_alloc_cnt;
   logic [`EVB_BRRET_W-1:0] br_cnt;
   logic [`EVB_BRMIS_W-1:0] mis_cnt;
   logic [`EVB_DTLB_W-1:0] dtlb_cnt;
   logic [`EVB_L3REF_W-1:0] l3_ref_cnt;

   lane_popcount #(
      .LANES(`MAX_L2ALLOC_LANES),
      .OUT_W(`EVB_L2ALLOC_W)
   ) u_cnt_l2alloc (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_hit(l2_alloc_lane),
      .o_count(l2_alloc_cnt)
   );

   lane_popcount #(
      .LANES(`MAX_BRANCH_LANES),
      .OUT_W(`EVB_BRRET_W)
   ) u_cnt_br (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_hit(br_lane),
      .o_count(br_cnt)
   );

   lane_popcount #(
      .LANES(`MAX_BRANCH_LANES),
      .OUT_W(`EVB_BRMIS_W)
   ) u_cnt_mis (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_hit(mis_lane),
      .o_count(mis_cnt)
   );

   lane_popcount #(
      .LANES(2),
      .OUT_W(`EVB_DTLB_W)
   ) u_cnt_dtlb (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_hit(dtlb_lane),
      .o_count(dtlb_cnt)
   );

   lane_popcount #(
      .LANES(`MAX_READ_LANES),
      .OUT_W(`EVB_L3REF_W)
   ) u_cnt_l3ref (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_hit(l3_ref_lane),
      .o_count(l3_ref_cnt)
   );

   // ------------------------------------------------------------------
   // Single-bit flags, registered so all slices align in one cycle
   // ------------------------------------------------------------------
   logic [10:0] flags_d;
   logic [10:0] flags_q;

   assign flags_d = {l2tlb_hit, l3_access_hit, l3_alloc_hit, itlb_hit,
                     stall_be, stall_fe, chain_hit, i_cycle_event,
                     ttb_hit, 2'b00};

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         flags_q <= 11'h000;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ------------------------------------------------------------------
   // Bus assembly
   // ------------------------------------------------------------------
   logic [`EVB_MSB:0] bus_full;

   always_comb begin
      bus_full = '0;
      bus_full[`EVB_TTBW_BIT] = flags_q[2];
      bus_full[`EVB_BUSCYC_BIT] = flags_q[3];
      bus_full[`EVB_CHAIN_BIT] = flags_q[4];
      bus_full[`EVB_L2ALLOC_LSB +: `EVB_L2ALLOC_W] = l2_alloc_cnt;
      bus_full[`EVB_BRRET_LSB +: `EVB_BRRET_W] = br_cnt;
      bus_full[`EVB_BRMIS_LSB +: `EVB_BRMIS_W] = mis_cnt;
      bus_full[`EVB_STFE_BIT] = flags_q[5];
      bus_full[`EVB_STBE_BIT] = flags_q[6];
      bus_full[`EVB_DTLB_LSB +: `EVB_DTLB_W] = dtlb_cnt;
      bus_full[`EVB_ITLB_BIT] = flags_q[7];
      bus_full[`EVB_L3ALLOC_BIT] = flags_q[8];
      bus_full[`EVB_L3REF_LSB +: `EVB_L3REF_W] = l3_ref_cnt;
      bus_full[`EVB_L3ACC_BIT] = flags_q[9];
      bus_full[`EVB_L2TLB_BIT] = flags_q[10];
   end

   assign o_event_bus = bus_full[`EVB_MSB:`EVB_LSB];
endmodule : perf_event_bus_encoder

// File: perf_event_cfg.svh
// Bit positions and widths of the event bus slices for events 0x1c to 0x2d
`ifndef PERF_EVENT_CFG_SVH
`define PERF_EVENT_CFG_SVH

`define EVB_TTBW_BIT      46
`define EVB_BUSCYC_BIT    47
`define EVB_CHAIN_BIT     48
`define EVB_L2ALLOC_LSB   49
`define EVB_L2ALLOC_W     3
`define EVB_BRRET_LSB     52
`define EVB_BRRET_W       4
`define EVB_BRMIS_LSB     56
`define EVB_BRMIS_W       4
`define EVB_STFE_BIT      60
`define EVB_STBE_BIT      61
`define EVB_DTLB_LSB      62
`define EVB_DTLB_W        3
`define EVB_ITLB_BIT      65
`define EVB_L3ALLOC_BIT   66
`define EVB_L3REF_LSB     67
`define EVB_L3REF_W       3
`define EVB_L3ACC_BIT     70
`define EVB_L2TLB_BIT     71
`define EVB_MSB           71
`define EVB_LSB           46

`define MAX_BRANCH_LANES  8
`define MAX_L2ALLOC_LANES 4
`define MAX_READ_LANES    4
`define NUM_COUNTERS      6

`endif

// File: perf_event_pkg.sv
// Types shared by the event encoder, its checker, the counter model and the bench
package perf_event_pkg;
   `include "perf_event_cfg.svh"

   typedef enum logic [2:0] {
      TTB_EL1 = 3'h1,
      TTB_EL2 = 3'h2,
      TTB_EL12 = 3'h4
   } ttb_level_t;

   typedef logic [`EVB_MSB:`EVB_LSB] event_slice_t;
endpackage : perf_event_pkg

// File: lane_popcount.sv
// Registered population count of a vector of per-lane occurrence flags
module lane_popcount #(
   parameter int LANES = 4,
   parameter int OUT_W = 3
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // Occurrences
   input wire logic [LANES-1:0] i_hit,
   // Registered count
   output logic [OUT_W-1:0] o_count
);
   logic [OUT_W-1:0] count_d;
   logic [OUT_W-1:0] count_q;
   logic [OUT_W-1:0] partial [0:LANES];

   assign partial[0] = '0;
   generate
      for (genvar g = 0; g < LANES; g++) begin : g_sum
         assign partial[g+1] = partial[g] + OUT_W'(i_hit[g]);
      end
   endgenerate
   assign count_d = partial[LANES];

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   assign o_count = count_q;
endmodule : lane_popcount

// File: perf_event_bus_encoder_chk.sv
// Concurrent checks on the event bus encoder ports
module perf_event_bus_encoder_chk
   import perf_event_pkg::*;
(
   input wire logic i_clk_sys, i_rst_b,
   input wire logic i_ttb_write_retired, i_ttb_write_cond_pass,
   input wire logic [2:0] i_ttb_write_level,
   input wire logic i_ttb_write_base01, i_cycle_event,
   input wire logic [5:0] i_counter_overflow, i_counter_sel_chain,
   input wire logic [7:0] i_branch_retired, i_branch_condition_fail,
   input wire logic [7:0] i_branch_is_exc_or_dbg, i_branch_mispredicted,
   input wire logic [7:0] i_branch_flush,
   input wire logic i_fetch_available, i_dispatch_blocked,
   input wire logic i_dtlb_load_access, i_dtlb_store_access,
   input wire logic i_level2_tlb_refill, i_mmu_enable,
   input wire logic [3:0] i_ccu_read_return, i_ccu_read_cacheable,
   input wire logic [3:0] i_ccu_read_external, i_ccu_read_pf_stash,
   input wire event_slice_t o_event_bus
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   ttb_el1_only_a:
   assert property (o_event_bus[46] == $past(i_ttb_write_retired &
      i_ttb_write_cond_pass & i_ttb_write_base01 &
      (i_ttb_write_level == 3'h1))) else $error("ttb event wrong");
   bus_cycle_copy_a:
   assert property (o_event_bus[47] == $past(i_cycle_event))
      else $error("bus cycle wrong");
   chain_odd_only_a:
   assert property (o_event_bus[48] == $past(|(i_counter_sel_chain &
      {i_counter_overflow[4:0], 1'b0} & 6'h2a))) else $error("chain wrong");
   branch_count_a:
   assert property (o_event_bus[55:52] == 4'($countones($past(
      i_branch_retired & ~i_branch_condition_fail & ~i_branch_is_exc_or_dbg))))
      else $error("branch count wrong");
   mispredict_count_a:
   assert property (o_event_bus[59:56] == 4'($countones($past(
      i_branch_retired & ~i_branch_condition_fail & ~i_branch_is_exc_or_dbg
      & i_branch_mispredicted & i_branch_flush))))
      else $error("mispredict count wrong");
   stall_front_a:
   assert property (o_event_bus[60] == $past(!i_fetch_available))
      else $error("frontend stall missed");
   stall_back_a:
   assert property (o_event_bus[61] == $past(i_fetch_available &
      i_dispatch_blocked)) else $error("backend stall wrong");
   dtlb_sum_a:
   assert property (o_event_bus[64:62] == 3'($past(i_dtlb_load_access)) +
      3'($past(i_dtlb_store_access))) else $error("dtlb count wrong");
   l3_refill_count_a:
   assert property (o_event_bus[69:67] == 3'($countones($past(
      i_ccu_read_return & i_ccu_read_cacheable & i_ccu_read_external &
      ~i_ccu_read_pf_stash)))) else $error("l3 refill count wrong");
   l2tlb_mmu_gate_a:
   assert property (o_event_bus[71] == $past(i_level2_tlb_refill & i_mmu_enable))
      else $error("l2 tlb refill wrong");
endmodule : perf_event_bus_encoder_chk

// File: perf_counter_model.sv
// Counter-side model summing the branch and chain slices of the bus
module perf_counter_model
   import perf_event_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire event_slice_t i_event_bus,
   output logic [15:0] o_branch_total,
   output logic [15:0] o_chain_total
);
   // Wide slices add their value, so several branches land in one cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_branch_total <= 16'h0;
         o_chain_total <= 16'h0;
      end else begin
         o_branch_total <= o_branch_total + 16'(i_event_bus[55:52]);
         o_chain_total <= o_chain_total + 16'(i_event_bus[48]);
      end
   end
endmodule : perf_counter_model

// File: tb_perf_event_bus_encoder.sv
// Self-checking bench for the event bus encoder
module tb_perf_event_bus_encoder;
   timeunit 1ns;
   timeprecision 1ps;
   import perf_event_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   logic ttb_ret, ttb_pass, ttb_b01, cyc, fetch, blk, dld, dst, itlb;
   logic l2tlb, mmu, l3w, l3lf, wcache;
   logic [2:0] ttb_lvl;
   logic [5:0] ovf, sel;
   logic [3:0] l2w, l2lf, rret, rcache, rext, rpf;
   logic [7:0] br, bfail, bexc, bmis, bfl;
   event_slice_t bus;
   logic [15:0] br_total, chain_total;
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   perf_event_bus_encoder uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_ttb_write_retired(ttb_ret), .i_ttb_write_cond_pass(ttb_pass),
      .i_ttb_write_level(ttb_lvl), .i_ttb_write_base01(ttb_b01),
      .i_cycle_event(cyc), .i_counter_overflow(ovf),
      .i_counter_sel_chain(sel), .i_l2_fullline_write(l2w),
      .i_l2_write_linefill(l2lf), .i_branch_retired(br),
      .i_branch_condition_fail(bfail), .i_branch_is_exc_or_dbg(bexc),
      .i_branch_mispredicted(bmis), .i_branch_flush(bfl),
      .i_fetch_available(fetch), .i_dispatch_blocked(blk),
      .i_dtlb_load_access(dld), .i_dtlb_store_access(dst),
      .i_itlb_access(itlb), .i_level2_tlb_refill(l2tlb), .i_mmu_enable(mmu),
      .i_l3_fullline_write(l3w), .i_l3_write_linefill(l3lf),
      .i_ccu_read_return(rret), .i_ccu_read_cacheable(rcache),
      .i_ccu_read_external(rext), .i_ccu_read_pf_stash(rpf),
      .i_ccu_write_cacheable(wcache), .o_event_bus(bus));
   perf_counter_model partner (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
      .i_event_bus(bus), .o_branch_total(br_total),
      .o_chain_total(chain_total));
   task automatic summarize;
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk
   // Inputs change only at the falling edge, away from sampling
   task automatic go;
      @(negedge i_clk_sys);
      {ttb_ret, ttb_pass, ttb_b01, cyc, blk, dld, dst, itlb} = '0;
      {l2tlb, mmu, l3w, l3lf, wcache, ttb_lvl, ovf, sel} = '0;
      {l2w, l2lf, rret, rcache, rext, rpf, br, bfail, bexc, bmis, bfl} = '0;
      fetch = 1'b1;
   endtask : go
   task automatic step;
      @(posedge i_clk_sys);
      #1;
   endtask : step
   task automatic s_ttb;
      for (int i = 0; i < 4; i++) begin
         go;
         {ttb_ret, ttb_b01, ttb_pass} = {2'b11, i != 3};
         ttb_lvl = (i < 3) ? 3'h1 << i : 3'h1;
         step;
         chk("ttb", bus[46], i == 0);
      end
   endtask : s_ttb
   task automatic s_chain;
      go;
      {ovf, sel, cyc} = {6'h15, 6'h2a, 1'b1};
      step;
      chk("chain", bus[48], 1);
      chk("bus cycle", bus[47], 1);
      go;
      {ovf, sel} = {6'h3f, 6'h15};
      step;
      chk("even chain", bus[48], 0);
   endtask : s_chain
   task automatic s_branch;
      go;
      br = 8'hff;
      step;
      chk("branch max", bus[55:52], 8);
      go;
      {br, bfail, bexc, bmis, bfl} = {8'hff, 8'h01, 8'h02, 8'h0f, 8'h0d};
      step;
      chk("branch", bus[55:52], 6);
      chk("mispredict", bus[59:56], 2);
   endtask : s_branch
   task automatic s_dispatch;
      go;
      {fetch, blk, dld, dst, itlb} = 5'b01111;
      step;
      chk("stalls", bus[61:60], 1);
      chk("dtlb pair", bus[64:62], 2);
      chk("itlb no mmu", bus[65], 1);
      go;
      {blk, dld} = 2'b11;
      step;
      chk("stalls busy", bus[61:60], 2);
      chk("dtlb one", bus[64:62], 1);
      chk("itlb idle", bus[65], 0);
   endtask : s_dispatch
   task automatic s_cache;
      go;
      {l2w, l2lf, l3w, l3lf} = {4'hf, 4'h1, 2'b11};
      {rret, rcache, rext, rpf} = {4'hf, 4'h7, 4'h5, 4'h4};
      step;
      chk("l2 alloc", bus[51:49], 3);
      chk("l3 alloc fill", bus[66], 0);
      chk("l3 refill", bus[69:67], 1);
      chk("l3 access rd", bus[70], 1);
      go;
      {l3w, wcache} = 2'b11;
      step;
      chk("l3 alloc", bus[66], 1);
      chk("l3 access wr", bus[70], 1);
   endtask : s_cache
   task automatic s_l2tlb;
      for (int i = 0; i < 2; i++) begin
         go;
         {l2tlb, mmu} = {1'b1, i == 1};
         step;
         chk("l2 tlb", bus[71], 8'(i));
      end
      go;
      step;
      chk("idle bus", bus == '0, 1);
      chk("branch total", br_total[7:0], 14);
      chk("chain total", chain_total[7:0], 1);
   endtask : s_l2tlb
   // Generous ceiling: the sequence needs well under a hundred cycles
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         summarize;
      end
   end
   initial begin
      go;
      repeat (12) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rst_b = 1'b1;
      step;
      chk("reset bus", bus == '0, 1);
      s_ttb;
      s_chain;
      s_branch;
      s_dispatch;
      s_cache;
      s_l2tlb;
      summarize;
   end
endmodule : tb_perf_event_bus_encoder
bind perf_event_bus_encoder perf_event_bus_encoder_chk chk_i (.*);
